// ==== pbgac_pkg.sv ====
// shared constants, register map and types for the synthesizer band, gain and auxiliary converter control
`default_nettype none
package pbgac_pkg;
   // device register map (three-wire port addresses)
   localparam logic [4:0] ADDR_STATUS   = 5'h00;
   localparam logic [4:0] ADDR_BAND     = 5'h08;
   localparam logic [4:0] ADDR_DIV      = 5'h09;
   localparam logic [4:0] ADDR_IGAIN_A  = 5'h0B;
   localparam logic [4:0] ADDR_IGAIN_B  = 5'h0C;
   localparam logic [4:0] ADDR_AUX1_MAG = 5'h0D;
   localparam logic [4:0] ADDR_AUX1_CTL = 5'h0E;
   localparam logic [4:0] ADDR_QGAIN_A  = 5'h0F;
   localparam logic [4:0] ADDR_QGAIN_B  = 5'h10;
   localparam logic [4:0] ADDR_AUX2_MAG = 5'h11;
   localparam logic [4:0] ADDR_AUX2_CTL = 5'h12;
   localparam int         REG_TOP       = 18;
   // fields
   localparam int         LOCK_BIT      = 1;
   localparam int         BAND_MSB      = 7;
   localparam int         BAND_LSB      = 2;
   localparam int         DIV1_LSB      = 5;
   localparam int         DIV2_LSB      = 3;
   localparam int         AUX_PIN_BIT   = 7;
   localparam int         AUX_SINK_BIT  = 6;
   localparam int         RW_BIT        = 7;
   localparam logic [5:0] BAND_AUTO     = 6'h3F;
   localparam logic [5:0] BAND_LOW_TOP  = 6'h1F;
   localparam logic [5:0] BAND_MAX      = 6'h3E;
   localparam logic [9:0] GAIN_RESET    = 10'h1F9;
   localparam logic [9:0] GAIN_STEP     = 10'h004;
   localparam logic [1:0] AUX_PIN_A_EN  = 2'h1;
   localparam logic [1:0] AUX_PIN_B_EN  = 2'h2;
   // timing
   localparam int         CLK_HZ        = 25_000_000;
   localparam int         LOCK_TIME_MS  = 5;
   localparam int         LOCK_CYCLES   = CLK_HZ / 1000 * LOCK_TIME_MS;
   localparam logic [3:0] SCLK_HALF     = 4'hB;
   localparam logic [4:0] INSTR_BITS    = 5'h08;
   localparam logic [4:0] XFER_BITS     = 5'h10;
   // controller register port map
   localparam logic [3:0] HR_CTRL       = 4'h0;
   localparam logic [3:0] HR_ADDR       = 4'h1;
   localparam logic [3:0] HR_WDATA      = 4'h2;
   localparam logic [3:0] HR_RDATA      = 4'h3;
   localparam logic [3:0] HR_STATUS     = 4'h4;
   localparam logic [3:0] HR_CAL        = 4'h5;
   localparam logic [3:0] HR_BAND       = 4'h6;
   localparam logic [3:0] HR_GAIN       = 4'h7;
   localparam logic [3:0] HR_AUXCFG     = 4'h8;
   localparam int         CMD_WRITE     = 0;
   localparam int         CMD_READ      = 1;
   localparam int         CMD_CAL       = 2;
   localparam int         CMD_RESTORE   = 3;
   localparam int         CMD_GAIN      = 4;
   localparam int         AUXCFG_FINAL  = 2;

   typedef enum logic [3:0] {
      S_BOOT     = 4'h0,
      S_IDLE     = 4'h1,
      S_WAIT     = 4'h2,
      S_RESTORE  = 4'h3,
      S_CAL_AUTO = 4'h4,
      S_CAL_LOCK = 4'h5,
      S_CAL_READ = 4'h6,
      S_CAL_DONE = 4'h7,
      S_RDONE    = 4'h8,
      S_GAIN_HI  = 4'h9
   } pbgac_state_t;

   // three-flop input filter: a change counts once second and third stages agree
   function automatic logic pbgac_filt(input logic [2:0] s, input logic f);
      return (s[1] == s[2]) ? s[2] : f;
   endfunction
endpackage
`default_nettype wire

// ==== pbgac_if.sv ====
// three-wire serial port and lock pin between the controller and the converter device
`default_nettype none
interface pbgac_if;
   logic sclk;
   logic cs_n;
   logic sdio_host_o;
   logic sdio_host_oe_n;
   logic sdio_dev_o;
   logic sdio_dev_oe_n;
   logic sdio_line;
   logic pll_lock;

   // shared data wire, pulled high when nobody drives
   assign sdio_line = !sdio_host_oe_n ? sdio_host_o : (!sdio_dev_oe_n ? sdio_dev_o : 1'b1);

   modport host (output sclk, output cs_n, output sdio_host_o, output sdio_host_oe_n,
                 input sdio_line, input pll_lock);
   modport dev  (input sclk, input cs_n, input sdio_line, output sdio_dev_o,
                 output sdio_dev_oe_n, output pll_lock);
endinterface
`default_nettype wire

// ==== pbgac_dev.sv ====
// device end: three-wire slave, band/lock, gain and auxiliary converter registers
`default_nettype none
module pbgac_dev
   import pbgac_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   pbgac_if.dev            port,
   input  wire logic       pll_lock_raw,
   input  wire logic [5:0] found_band,
   output var logic  [5:0] band_sel,
   output var logic        auto_search,
   output var logic  [1:0] first_loop_divider,
   output var logic  [1:0] second_loop_divider,
   output var logic  [9:0] i_gain,
   output var logic  [9:0] q_gain,
   output var logic  [9:0] aux1_mag,
   output var logic  [9:0] aux2_mag,
   output var logic  [1:0] aux1_pin_en,
   output var logic  [1:0] aux2_pin_en,
   output var logic        aux1_sink,
   output var logic        aux2_sink
);
   typedef struct packed {
      logic [2:0]           sclk_s;
      logic [2:0]           cs_s;
      logic [2:0]           sdio_s;
      logic [2:0]           lock_s;
      logic                 sclk_f;
      logic                 cs_f;
      logic                 sdio_f;
      logic                 lock_f;
      logic [7:0]           shift;
      logic [4:0]           cnt;
      logic                 rd;
      logic [4:0]           addr;
      logic [7:0]           rdata;
      logic                 sdo;
      logic                 sdo_oe_n;
      logic                 auto;
      logic [5:0]           found;
      logic [1:0]           aux1_en;
      logic [1:0]           aux2_en;
      logic [REG_TOP:0][7:0] regs;
   } pbgac_dev_st_t;

   pbgac_dev_st_t st_reg;
   pbgac_dev_st_t st_next;

   function automatic logic writable(input logic [4:0] a);
      return a == ADDR_BAND || a == ADDR_DIV || (a >= ADDR_IGAIN_A && a <= ADDR_AUX2_CTL);
   endfunction

   function automatic pbgac_dev_st_t reset_state();
      pbgac_dev_st_t s;
      s = '0;
      s.cs_s = '1;
      s.cs_f = 1'b1;
      s.sdo_oe_n = 1'b1;
      s.aux1_en = AUX_PIN_A_EN;
      s.aux2_en = AUX_PIN_A_EN;
      {s.regs[ADDR_IGAIN_B], s.regs[ADDR_IGAIN_A]} = {6'h00, GAIN_RESET};
      {s.regs[ADDR_QGAIN_B], s.regs[ADDR_QGAIN_A]} = {6'h00, GAIN_RESET};
      return s;
   endfunction

   always_comb begin
      st_next = st_reg;
      st_next.sclk_s = {st_reg.sclk_s[1:0], port.sclk};
      st_next.cs_s = {st_reg.cs_s[1:0], port.cs_n};
      st_next.sdio_s = {st_reg.sdio_s[1:0], port.sdio_line};
      st_next.lock_s = {st_reg.lock_s[1:0], pll_lock_raw};
      st_next.sclk_f = pbgac_filt(st_reg.sclk_s, st_reg.sclk_f);
      st_next.cs_f = pbgac_filt(st_reg.cs_s, st_reg.cs_f);
      st_next.sdio_f = pbgac_filt(st_reg.sdio_s, st_reg.sdio_f);
      st_next.lock_f = pbgac_filt(st_reg.lock_s, st_reg.lock_f);
      // the search result is quasi-static once lock is reached, so it is taken on the lock rise
      if (st_next.lock_f && !st_reg.lock_f) begin
         st_next.found = found_band;
      end
      st_next.regs[ADDR_STATUS] = '0;
      st_next.regs[ADDR_STATUS][LOCK_BIT] = st_reg.lock_f;
      if (st_reg.cs_f) begin
         st_next.cnt = '0;
         st_next.rd = 1'b0;
         st_next.sdo_oe_n = 1'b1;
      end else if (st_next.sclk_f && !st_reg.sclk_f) begin
         st_next.shift = {st_reg.shift[6:0], st_reg.sdio_f};
         if (st_reg.cnt != XFER_BITS) begin
            st_next.cnt = st_reg.cnt + 5'h01;
         end
         if (st_reg.cnt == INSTR_BITS - 5'h01) begin
            st_next.rd = st_next.shift[RW_BIT];
            st_next.addr = st_next.shift[4:0];
            st_next.rdata = (st_next.shift[4:0] > 5'(REG_TOP)) ? 8'h00 : st_reg.regs[st_next.shift[4:0]];
            if (st_next.shift[4:0] == ADDR_BAND && st_reg.auto && st_reg.lock_f) begin
               st_next.rdata[BAND_MSB:BAND_LSB] = st_reg.found;
            end
         end
         if (st_reg.cnt == XFER_BITS - 5'h01 && !st_reg.rd && writable(st_reg.addr)) begin
            st_next.regs[st_reg.addr] = st_next.shift;
            unique case (st_reg.addr)
               ADDR_BAND: st_next.auto = st_next.shift[BAND_MSB:BAND_LSB] == BAND_AUTO;
               ADDR_AUX1_CTL: st_next.aux1_en = st_next.shift[AUX_PIN_BIT] ? AUX_PIN_B_EN : AUX_PIN_A_EN;
               ADDR_AUX2_CTL: st_next.aux2_en = st_next.shift[AUX_PIN_BIT] ? AUX_PIN_B_EN : AUX_PIN_A_EN;
               default: ;
            endcase
         end
      end else if (!st_next.sclk_f && st_reg.sclk_f && st_reg.rd && st_reg.cnt >= INSTR_BITS
                   && st_reg.cnt < XFER_BITS) begin
         st_next.sdo = st_reg.rdata[7];
         st_next.rdata = {st_reg.rdata[6:0], 1'b0};
         st_next.sdo_oe_n = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= reset_state();
      end else begin
         st_reg <= st_next;
      end
   end

   assign port.sdio_dev_o = st_reg.sdo;
   assign port.sdio_dev_oe_n = st_reg.sdo_oe_n;
   assign port.pll_lock = st_reg.lock_f;
   assign band_sel = st_reg.regs[ADDR_BAND][BAND_MSB:BAND_LSB];
   assign auto_search = st_reg.auto;
   assign first_loop_divider = st_reg.regs[ADDR_DIV][DIV1_LSB+1:DIV1_LSB];
   assign second_loop_divider = st_reg.regs[ADDR_DIV][DIV2_LSB+1:DIV2_LSB];
   assign i_gain = {st_reg.regs[ADDR_IGAIN_B][1:0], st_reg.regs[ADDR_IGAIN_A]};
   assign q_gain = {st_reg.regs[ADDR_QGAIN_B][1:0], st_reg.regs[ADDR_QGAIN_A]};
   assign aux1_mag = {st_reg.regs[ADDR_AUX1_CTL][1:0], st_reg.regs[ADDR_AUX1_MAG]};
   assign aux2_mag = {st_reg.regs[ADDR_AUX2_CTL][1:0], st_reg.regs[ADDR_AUX2_MAG]};
   assign aux1_pin_en = st_reg.aux1_en;
   assign aux2_pin_en = st_reg.aux2_en;
   assign aux1_sink = st_reg.regs[ADDR_AUX1_CTL][AUX_SINK_BIT];
   assign aux2_sink = st_reg.regs[ADDR_AUX2_CTL][AUX_SINK_BIT];
endmodule
`default_nettype wire

// ==== pbgac_host.sv ====
// controller end: three-wire master with band calibration, band restore and gain stepping
// Behaviour
// - band code 63 starts automatic band search
// - lock raises pin and status bit 1
// - band readback gives the searched band
// - program both loop dividers before search
// - store adjusted band, rewrite it at start
// - correction rule depends on low/high band
// - ten-bit channel gains in register pairs
// - ten-bit auxiliary magnitudes in register pairs
// - bit 7 picks active aux pin
// - bit 6 picks source or sink
// - step one gain, measure image, switch
// - finish gain before auxiliary adjustment
// - source/sink choice fixed at design time; here taken from HR_AUXCFG bits 0 and 1, writable at run time
`default_nettype none
module pbgac_host
   import pbgac_pkg::*;
#(
   parameter int LOCK_WAIT_CYCLES = LOCK_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   pbgac_if.host           port,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var logic  [7:0] reg_rdata,
   input  wire logic [5:0] nvm_band,
   input  wire logic       nvm_valid,
   output var logic  [5:0] nvm_store_band,
   output var logic        nvm_store
);
   typedef struct packed {
      pbgac_state_t state;
      pbgac_state_t ret;
      logic         act;
      logic [4:0]   bitn;
      logic [3:0]   phase;
      logic         sclk;
      logic         cs_n;
      logic         sdo;
      logic         sdo_oe_n;
      logic         rdx;
      logic [15:0]  tx;
      logic [7:0]   rx;
      logic [2:0]   sdi_s;
      logic         sdi_f;
      logic [2:0]   lock_s;
      logic         lock_f;
      logic [23:0]  tmo;
      logic [4:0]   tgt;
      logic [7:0]   wdata;
      logic [7:0]   rdata;
      logic [6:0]   cal;
      logic [5:0]   band;
      logic [2:0]   auxcfg;
      logic         gain_q;
      logic [9:0]   igain;
      logic [9:0]   qgain;
      logic         cal_ok;
      logic         cal_fail;
      logic         restored;
      logic         refused;
      logic [7:0]   bus_q;
      logic         store;
   } pbgac_host_st_t;

   pbgac_host_st_t st_reg;
   pbgac_host_st_t st_next;

   function automatic pbgac_host_st_t launch(input pbgac_host_st_t s, input logic rdf, input logic [4:0] a,
                                            input logic [7:0] d, input pbgac_state_t nxt);
      pbgac_host_st_t r;
      r = s;
      r.tx = {rdf, 2'b00, a, d};
      r.rdx = rdf;
      r.act = 1'b1;
      r.bitn = '0;
      r.phase = '0;
      r.cs_n = 1'b0;
      r.sdo = rdf;
      r.sdo_oe_n = 1'b0;
      r.state = S_WAIT;
      r.ret = nxt;
      return r;
   endfunction

   // temperature code: 0 -40..-30, 1 -30..-10, 2 -10..15, 3 15..55, 4 55..85
   function automatic logic [5:0] band_correct(input logic [5:0] b, input logic [2:0] t);
      logic [6:0] v;
      v = {1'b0, b};
      unique case (t)
         3'h0:    v = v + ((b > BAND_LOW_TOP) ? 7'h03 : 7'h02);
         3'h1:    v = v + 7'h02;
         3'h2:    v = v + 7'h01;
         3'h4:    v = (b == 6'h00) ? v : v - 7'h01;
         default: v = v;
      endcase
      return (v > {1'b0, BAND_MAX}) ? BAND_MAX : v[5:0];
   endfunction

   function automatic logic [9:0] gain_step(input logic [9:0] g, input logic down);
      if (down) begin
         return (g < GAIN_STEP) ? 10'h000 : g - GAIN_STEP;
      end
      return (g > 10'h3FF - GAIN_STEP) ? 10'h3FF : g + GAIN_STEP;
   endfunction

   function automatic logic is_aux(input logic [4:0] a);
      return a == ADDR_AUX1_MAG || a == ADDR_AUX1_CTL || a == ADDR_AUX2_MAG || a == ADDR_AUX2_CTL;
   endfunction

   always_comb begin
      logic       cmd;
      logic [7:0] d;
      logic [9:0] g;
      cmd = reg_wr && reg_addr == HR_CTRL;
      d = st_reg.wdata;
      g = '0;
      st_next = st_reg;
      st_next.store = 1'b0;
      st_next.sdi_s = {st_reg.sdi_s[1:0], port.sdio_line};
      st_next.lock_s = {st_reg.lock_s[1:0], port.pll_lock};
      st_next.sdi_f = pbgac_filt(st_reg.sdi_s, st_reg.sdi_f);
      st_next.lock_f = pbgac_filt(st_reg.lock_s, st_reg.lock_f);
      // serial engine: data changes with sclk low, both ends sample on the rise
      if (st_reg.act) begin
         st_next.phase = st_reg.phase + 4'h1;
         if (st_reg.phase == SCLK_HALF) begin
            st_next.phase = '0;
            if (st_reg.bitn == XFER_BITS) begin
               st_next.act = 1'b0;
            end else if (!st_reg.sclk) begin
               st_next.sclk = 1'b1;
               st_next.rx = {st_reg.rx[6:0], st_reg.sdi_f};
            end else begin
               st_next.sclk = 1'b0;
               st_next.bitn = st_reg.bitn + 5'h01;
               st_next.tx = {st_reg.tx[14:0], 1'b0};
               st_next.sdo = st_next.tx[15];
               // the tail half keeps chip select high long enough for the far filter
               st_next.cs_n = st_next.bitn == XFER_BITS;
               st_next.sdo_oe_n = st_next.cs_n || (st_reg.rdx && st_next.bitn >= INSTR_BITS);
            end
         end
      end
      if (reg_wr) begin
         unique case (reg_addr)
            HR_ADDR:   st_next.tgt = reg_wdata[4:0];
            HR_WDATA:  st_next.wdata = reg_wdata;
            HR_CAL:    st_next.cal = reg_wdata[6:0];
            HR_BAND:   st_next.band = reg_wdata[5:0];
            HR_AUXCFG: st_next.auxcfg = reg_wdata[2:0];
            default: ;
         endcase
      end
      if (cmd && st_reg.state != S_IDLE) begin
         st_next.refused = 1'b1;
      end
      unique case (st_reg.state)
         S_BOOT: begin
            st_next.band = nvm_band;
            st_next.state = nvm_valid ? S_RESTORE : S_IDLE;
         end
         S_IDLE: begin
            if (cmd) begin
               st_next.refused = 1'b0;
               if (reg_wdata[CMD_WRITE]) begin
                  if (st_reg.tgt == ADDR_AUX1_CTL) begin
                     d[AUX_SINK_BIT] = st_reg.auxcfg[0];
                  end
                  if (st_reg.tgt == ADDR_AUX2_CTL) begin
                     d[AUX_SINK_BIT] = st_reg.auxcfg[1];
                  end
                  if (is_aux(st_reg.tgt) && !st_reg.auxcfg[AUXCFG_FINAL]) begin
                     st_next.refused = 1'b1;
                  end else begin
                     st_next = launch(st_next, 1'b0, st_reg.tgt, d, S_IDLE);
                  end
               end else if (reg_wdata[CMD_READ]) begin
                  st_next = launch(st_next, 1'b1, st_reg.tgt, 8'h00, S_RDONE);
               end else if (reg_wdata[CMD_CAL]) begin
                  st_next.cal_ok = 1'b0;
                  st_next.cal_fail = 1'b0;
                  d = {1'b0, st_reg.cal[3:2], st_reg.cal[1:0], 3'h0};
                  st_next = launch(st_next, 1'b0, ADDR_DIV, d, S_CAL_AUTO);
               end else if (reg_wdata[CMD_RESTORE]) begin
                  st_next.state = S_RESTORE;
               end else if (reg_wdata[CMD_GAIN]) begin
                  // one fixed step per command; software measures the image between steps
                  st_next.gain_q = st_reg.wdata[0];
                  g = gain_step(st_reg.wdata[0] ? st_reg.qgain : st_reg.igain, st_reg.wdata[1]);
                  if (st_reg.wdata[0]) begin
                     st_next.qgain = g;
                  end else begin
                     st_next.igain = g;
                  end
                  st_next = launch(st_next, 1'b0, st_reg.wdata[0] ? ADDR_QGAIN_A : ADDR_IGAIN_A,
                                   g[7:0], S_GAIN_HI);
               end
            end
         end
         S_WAIT: begin
            if (!st_reg.act) begin
               st_next.state = st_reg.ret;
            end
         end
         S_RESTORE: begin
            st_next.restored = 1'b1;
            st_next = launch(st_next, 1'b0, ADDR_BAND, {st_reg.band, 2'b00}, S_IDLE);
         end
         S_CAL_AUTO: begin
            st_next.tmo = '0;
            st_next = launch(st_next, 1'b0, ADDR_BAND, {BAND_AUTO, 2'b00}, S_CAL_LOCK);
         end
         S_CAL_LOCK: begin
            st_next.tmo = st_reg.tmo + 24'h00_0001;
            if (st_reg.lock_f) begin
               st_next.state = S_CAL_READ;
            end else if (st_reg.tmo == 24'(LOCK_WAIT_CYCLES - 1)) begin
               st_next.cal_fail = 1'b1;
               st_next.state = S_IDLE;
            end
         end
         S_CAL_READ: begin
            st_next = launch(st_next, 1'b1, ADDR_BAND, 8'h00, S_CAL_DONE);
         end
         S_CAL_DONE: begin
            st_next.band = band_correct(st_reg.rx[BAND_MSB:BAND_LSB], st_reg.cal[6:4]);
            st_next.store = 1'b1;
            st_next.cal_ok = 1'b1;
            st_next.state = S_RESTORE;
         end
         S_RDONE: begin
            st_next.rdata = st_reg.rx;
            st_next.state = S_IDLE;
         end
         S_GAIN_HI: begin
            g = st_reg.gain_q ? st_reg.qgain : st_reg.igain;
            st_next = launch(st_next, 1'b0, st_reg.gain_q ? ADDR_QGAIN_B : ADDR_IGAIN_B,
                             {6'h00, g[9:8]}, S_IDLE);
         end
         default: st_next.state = S_IDLE;
      endcase
      st_next.bus_q = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            HR_ADDR:   st_next.bus_q = {3'h0, st_reg.tgt};
            HR_WDATA:  st_next.bus_q = st_reg.wdata;
            HR_RDATA:  st_next.bus_q = st_reg.rdata;
            HR_STATUS: st_next.bus_q = {2'h0, st_reg.lock_f, st_reg.refused, st_reg.restored,
                                        st_reg.cal_fail, st_reg.cal_ok, st_reg.state != S_IDLE};
            HR_CAL:    st_next.bus_q = {1'b0, st_reg.cal};
            HR_BAND:   st_next.bus_q = {2'h0, st_reg.band};
            HR_AUXCFG: st_next.bus_q = {5'h00, st_reg.auxcfg};
            default:   st_next.bus_q = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '{state: S_BOOT, ret: S_IDLE, cs_n: 1'b1, sdo_oe_n: 1'b1, igain: GAIN_RESET,
                     qgain: GAIN_RESET, cal: 7'h03, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign port.sclk = st_reg.sclk;
   assign port.cs_n = st_reg.cs_n;
   assign port.sdio_host_o = st_reg.sdo;
   assign port.sdio_host_oe_n = st_reg.sdo_oe_n;
   assign reg_rdata = st_reg.bus_q;
   assign nvm_store_band = st_reg.band;
   assign nvm_store = st_reg.store;
endmodule
`default_nettype wire

// ==== pbgac_props.sv ====
// wire-level assertions on the three-wire port joining controller and device
`default_nettype none
module pbgac_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_host_oe_n,
   input wire logic sdio_dev_oe_n,
   input wire logic pll_lock
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] rise_reg;
   logic       sclk_reg;
   // counts serial clock rises inside the current frame
   always_ff @(posedge clk) begin
      sclk_reg <= sclk;
      rise_reg <= (rst || cs_n) ? 5'h00 : rise_reg + 5'(sclk && !sclk_reg);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_IDLE_CLK: assert property (cs_n |-> !sclk) else $error("clock outside frame");
   AST_HOST_IDLE: assert property (cs_n |-> sdio_host_oe_n) else $error("host drives outside frame");
   // device sees chip select through a filter, so allow it a few cycles
   AST_DEV_IDLE: assert property (cs_n [*8] |-> sdio_dev_oe_n) else $error("device drives outside frame");
   AST_ONE_DRV: assert property (sdio_host_oe_n || sdio_dev_oe_n) else $error("both ends drive");
   AST_HIGH_HALF: assert property ($rose(sclk) |-> sclk [*8] ##1 sclk [*4] ##1 !sclk) else $error("bad high");
   AST_LOW_HALF: assert property ($fell(sclk) && !cs_n |-> !sclk [*8] ##1 !sclk [*4]) else $error("bad low");
   AST_START: assert property ($fell(cs_n) |-> !sclk [*8] ##1 !sclk [*4] ##1 sclk) else $error("bad start");
   AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_reg == 5'h10) else $error("frame not 16 bits");
   cover property ($rose(cs_n));
   cover property ($rose(pll_lock));
   cover property (!sdio_dev_oe_n);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench: controller and device joined over the three-wire port
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pbgac_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, lk = 1'b0, lk_en = 1'b0, auto, s1, s2, nst;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wd = 8'h00, rdat, st;
   logic [5:0]  fb = 6'h00, sb, nsb;
   logic [1:0]  d1, d2, p1, p2;
   logic [9:0]  ig, qg, m1, m2, gi = GAIN_RESET, gq = GAIN_RESET;
   logic [31:0] lf = 32'h538b_454a;
   int          errors = 0, samples_checked = 0, k, ns = 0;
   pbgac_if bus ();
   always #20 clk = ~clk;
   // lock follows the search request only when the scenario lets it
   always @(posedge clk) lk <= auto && lk_en;
   // calibration results handed to nonvolatile storage
   always @(posedge clk) if (nst) ns <= ns + 1;
   pbgac_dev pbgac_dev_i (.clk(clk), .rst(rst), .port(bus), .pll_lock_raw(lk), .found_band(fb), .band_sel(sb),
      .auto_search(auto), .first_loop_divider(d1), .second_loop_divider(d2), .i_gain(ig), .q_gain(qg),
      .aux1_mag(m1), .aux2_mag(m2), .aux1_pin_en(p1), .aux2_pin_en(p2), .aux1_sink(s1), .aux2_sink(s2));
   pbgac_host #(.LOCK_WAIT_CYCLES(200)) pbgac_host_i (.clk(clk), .rst(rst), .port(bus), .reg_addr(addr),
      .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .nvm_band(6'h2A), .nvm_valid(1'b1),
      .nvm_store_band(nsb), .nvm_store(nst));
   pbgac_props pbgac_props_i (.clk(clk), .rst(rst), .sclk(bus.sclk), .cs_n(bus.cs_n), .pll_lock(bus.pll_lock),
      .sdio_host_oe_n(bus.sdio_host_oe_n), .sdio_dev_oe_n(bus.sdio_dev_oe_n));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [9:0] corr(input logic [5:0] b, input int t);
      int d;
      d = int'(b) + ((t == 0) ? ((b > 6'h1F) ? 3 : 2) : (t == 1) ? 2 : (t == 2) ? 1 : (t == 4) ? -1 : 0);
      return (d < 0) ? 10'h000 : (d > 62) ? 10'h03E : 10'(d);
   endfunction
   // the controller steps its own copy of the gain, saturating at both ends
   function automatic logic [9:0] stp(input logic [9:0] g, input logic dn);
      int v;
      v = dn ? int'(g) - int'(GAIN_STEP) : int'(g) + int'(GAIN_STEP);
      return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : 10'(v);
   endfunction
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic hw(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic hr(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdat;
   endtask
   // bounded poll of the busy flag; a hang ends the run
   task automatic idle();
      for (k = 0; k < 3000; k++) begin
         hr(HR_STATUS, st);
         if (st[0] === 1'b0) return;
      end
      errors++;
      end_sim();
   endtask
   task automatic op(input logic [7:0] c, input logic [4:0] a, input logic [7:0] d);
      hw(HR_ADDR, {3'h0, a});
      hw(HR_WDATA, d);
      hw(HR_CTRL, c);
      idle();
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      end_sim();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(ig, GAIN_RESET);
      idle();
      chk({4'h0, sb}, 10'h02A);
      op(8'h01, ADDR_AUX1_MAG, 8'h55);
      chk({9'h000, st[4]}, 10'h001);
      chk(m1, 10'h000);
      for (int i = 0; i < 3; i++) begin
         lf = nxt(lf);
         hw(HR_AUXCFG, {5'h00, 1'b1, lf[21:20]});
         op(8'h01, ADDR_IGAIN_A, lf[7:0]);
         op(8'h01, ADDR_IGAIN_B, {6'h00, lf[9:8]});
         op(8'h01, ADDR_QGAIN_A, lf[17:10]);
         op(8'h01, ADDR_QGAIN_B, {6'h00, lf[19:18]});
         op(8'h01, ADDR_AUX1_MAG, lf[29:22]);
         op(8'h01, ADDR_AUX1_CTL, {lf[31:30], 4'h0, lf[9:8]});
         op(8'h01, ADDR_AUX2_MAG, lf[17:10]);
         op(8'h01, ADDR_AUX2_CTL, {~lf[31], 5'h00, lf[19:18]});
         chk(qg, lf[19:10]);
         chk(m1, {lf[9:8], lf[29:22]});
         chk(m2, lf[19:10]);
         chk({6'h00, p1, p2}, lf[31] ? 10'h009 : 10'h006);
         chk({8'h00, s2, s1}, {8'h00, lf[21:20]});
         op(8'h10, 5'h00, {6'h00, lf[1:0]});
         gi = lf[0] ? gi : stp(gi, lf[1]);
         gq = lf[0] ? stp(gq, lf[1]) : gq;
         chk(lf[0] ? qg : ig, lf[0] ? gq : gi);
      end
      for (int t = 0; t < 6; t++) begin
         lf = nxt(lf);
         fb <= (t == 0) ? 6'h3E : (t == 4) ? 6'h00 : lf[5:0] & 6'h3D;
         lk_en <= (t != 5);
         hw(HR_CAL, {1'b0, 3'(t), lf[9:6]});
         op(8'h04, 5'h00, 8'h00);
         chk({8'h00, st[2:1]}, (t == 5) ? 10'h002 : 10'h001);
         if (t < 5) begin
            chk({4'h0, sb}, corr(fb, t));
            chk({4'h0, nsb}, corr(fb, t));
            chk({6'h00, d1, d2}, {6'h00, lf[9:6]});
         end
      end
      chk(10'(ns), 10'h005);
      lk_en <= 1'b1;
      op(8'h01, ADDR_BAND, 8'hFC);
      chk({8'h00, auto, bus.pll_lock}, 10'h003);
      op(8'h02, ADDR_BAND, 8'h00);
      hr(HR_RDATA, st);
      chk({4'h0, st[7:2]}, {4'h0, fb});
      op(8'h02, ADDR_STATUS, 8'h00);
      hr(HR_RDATA, st);
      chk({2'h0, st}, 10'h002);
      hw(HR_BAND, {2'h0, lf[15:10]});
      op(8'h08, 5'h00, 8'h00);
      chk({4'h0, sb}, {4'h0, lf[15:10]});
      end_sim();
   end
endmodule
`default_nettype wire
